// *** rtl/sfds_channel.sv ***
/*
 * sfds_channel: one output channel's protection/diagnostic sequencer.
 * Assumes sense inputs synchronous to clk and a one-cycle re-arm pulse per host read.
 */
`timescale 1ns/1ps
`default_nettype none

module sfds_channel
    import sfds_pkg::*;
#(
    parameter int RECHECK_CYC = SFDS_RECHECK_CYC,
    parameter int ACQ_CYC = SFDS_ACQ_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic diag_en,
    input wire logic line_mode,
    input wire logic biased,
    input wire logic turn_on_go,
    input wire logic rearm,
    input wire sfds_sense_type sense,
    // status
    output logic ch_active,
    output logic turn_on_busy,
    output sfds_record_type record
);

    typedef enum logic [2:0] {
        CH_IDLE, CH_TON_ACQ, CH_RUN, CH_RECHECK, CH_DIAG, CH_RESTART
    } sfds_ch_state_type;

    sfds_ch_state_type state;
    sfds_ch_state_type next_state;
    logic [SFDS_CNT_W-1:0] cnt;
    logic [SFDS_CNT_W-1:0] next_cnt;
    logic armed;
    logic offset_run;

    // classify by priority: ground, supply, then load
    // R2: four fault classes
    function automatic sfds_fault_type classify(input sfds_sense_type s, input logic line,
                                                input logic with_open);
        logic sh;
        logic op;
        sh = line ? s.load_short_line : s.load_short_spk;
        op = line ? s.load_open_line : s.load_open_spk;
        if (s.short_gnd) classify = SFDS_FLT_GND;
        else if (s.short_vs) classify = SFDS_FLT_VS;
        else if (sh) classify = SFDS_FLT_ACROSS;
        else if (op && with_open) classify = SFDS_FLT_OPEN;
        else classify = SFDS_FLT_NONE;
    endfunction

    wire logic cnt_done = (cnt == '0);
    wire logic overload = sense.protect_trip || sense.short_gnd || sense.short_vs;
    wire sfds_fault_type ton_class = classify(sense, line_mode, 1'b1);
    wire sfds_fault_type perm_class = classify(sense, line_mode, 1'b0);

    always_comb begin
        next_state = state;
        next_cnt = cnt - 1'b1;
        if (cnt_done) next_cnt = cnt;
        case (state)
            CH_IDLE: begin
                // R1: pulse launch on request
                if (turn_on_go && armed) begin
                    next_state = CH_TON_ACQ;
                    next_cnt = SFDS_CNT_W'(ACQ_CYC - 1);
                end else if (biased) begin
                    next_state = CH_RUN;
                end
            end
            CH_TON_ACQ: begin
                if (cnt_done) next_state = biased ? CH_RUN : CH_IDLE;
            end
            CH_RUN: begin
                if (!biased) begin
                    next_state = CH_IDLE;
                end else if (sense.protect_trip) begin
                    // R9: only this channel goes down
                    // R11: trip starts diagnostic
                    next_state = (diag_en && armed) ? CH_RECHECK : CH_RESTART;
                    next_cnt = SFDS_CNT_W'(RECHECK_CYC - 1);
                end
            end
            CH_RECHECK: begin
                // R12: recheck after 1 ms
                if (cnt_done) begin
                    if (!overload) begin
                        next_state = CH_RUN;
                    end else begin
                        // R13: long diagnostic cycle
                        next_state = CH_DIAG;
                        next_cnt = SFDS_CNT_W'(ACQ_CYC - 1);
                    end
                end
            end
            CH_DIAG: begin
                // R14: diagnostic ends in restart
                if (cnt_done) begin
                    next_state = CH_RESTART;
                    next_cnt = SFDS_CNT_W'(RECHECK_CYC - 1);
                end
            end
            CH_RESTART: begin
                // R10: poll every 1 ms
                if (!biased) begin
                    next_state = CH_IDLE;
                end else if (cnt_done) begin
                    if (!overload) next_state = CH_RUN;
                    else next_cnt = SFDS_CNT_W'(RECHECK_CYC - 1);
                end
            end
            default: next_state = CH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= CH_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    wire logic ton_latch = (state == CH_TON_ACQ) && cnt_done;
    wire logic diag_latch = (state == CH_DIAG) && cnt_done;
    wire logic cycle_end = ton_latch || diag_latch;

    // R3: new pulse after read
    // R15: armed cleared at cycle end, set by read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b1;
        end else if (rearm) begin
            armed <= 1'b1;
        end else if (cycle_end) begin
            armed <= 1'b0;
        end
    end

    // R17: offset must persist from read to read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offset_run <= 1'b0;
        end else if (rearm) begin
            offset_run <= biased && diag_en;
        end else if (!sense.offset_high || sense.protect_trip || !biased) begin
            offset_run <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            record <= '0;
        end else begin
            // R6: sampled at end of the pulse plateau
            if (ton_latch) record.turn_on <= ton_class;
            // R8: no open load from permanent test
            if (diag_latch) record.permanent <= perm_class;
            if (rearm) record.offset <= offset_run;
        end
    end

    assign ch_active = (state == CH_RUN);
    assign turn_on_busy = (state == CH_TON_ACQ);

    // R12: clean recheck returns to run
    chk_recheck_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (state == CH_RECHECK && cnt_done && !overload) |=> state == CH_RUN)
        else $error("recheck did not reactivate channel");
    // R14: diagnostic ends in restart
    chk_diag_restart: assert property (@(posedge clk) disable iff (!rst_n)
        (state == CH_DIAG && cnt_done) |=> state == CH_RESTART)
        else $error("diagnostic did not end in restart");
    // R15: no new cycle until rearm
    chk_no_rearm: assert property (@(posedge clk) disable iff (!rst_n)
        (!armed && !rearm && state == CH_RUN) |=> state != CH_RECHECK)
        else $error("diagnostic started without rearm");
    // R8: permanent never reports open
    chk_perm_open: assert property (@(posedge clk) disable iff (!rst_n)
        record.permanent != SFDS_FLT_OPEN)
        else $error("open load reported by permanent test");
    // R11: armed trip with diagnostics on goes to recheck
    chk_trip_recheck: assert property (@(posedge clk) disable iff (!rst_n)
        (state == CH_RUN && biased && sense.protect_trip && diag_en && armed)
        |=> state == CH_RECHECK)
        else $error("protection trip did not start diagnostic");
    // R13: lasting overload starts the long cycle
    chk_recheck_diag: assert property (@(posedge clk) disable iff (!rst_n)
        (state == CH_RECHECK && cnt_done && overload) |=> state == CH_DIAG)
        else $error("overload at recheck did not start diagnostic");
    // R10: cleared overload ends restart
    chk_restart_poll: assert property (@(posedge clk) disable iff (!rst_n)
        (state == CH_RESTART && biased && cnt_done && !overload) |=> state == CH_RUN)
        else $error("restart did not reactivate channel");
    // R3: turn-on result held between pulses
    chk_ton_held: assert property (@(posedge clk) disable iff (!rst_n)
        !ton_latch |=> $stable(record.turn_on))
        else $error("turn-on result changed outside a pulse");

endmodule

`default_nettype wire

// *** rtl/sfds_pkg.sv ***
/*
 * sfds_pkg: shared types and constants for the speaker fault diagnostic sequencer.
 * Assumes a 100 MHz system clock; all times are converted to cycle counts here.
 */
package sfds_pkg;

    localparam int SFDS_CLK_MHZ = 100;
    localparam int SFDS_NUM_CH = 4;

    // times in their own unit
    localparam int SFDS_RECHECK_MS = 1;
    localparam int SFDS_ACQ_MS = 100;
    localparam int SFDS_CYC_PER_MS = SFDS_CLK_MHZ * 1000;
    localparam int SFDS_RECHECK_CYC = SFDS_RECHECK_MS * SFDS_CYC_PER_MS;
    localparam int SFDS_ACQ_CYC = SFDS_ACQ_MS * SFDS_CYC_PER_MS;

    localparam int SFDS_CNT_W = 24;

    // fault code layout
    typedef enum logic [2:0] {
        SFDS_FLT_NONE,
        SFDS_FLT_GND,
        SFDS_FLT_VS,
        SFDS_FLT_ACROSS,
        SFDS_FLT_OPEN,
        SFDS_FLT_OFFSET
    } sfds_fault_type;

    // analog comparator results for one channel
    typedef struct packed {
        logic short_gnd;
        logic short_vs;
        logic load_short_spk;
        logic load_open_spk;
        logic load_short_line;
        logic load_open_line;
        logic offset_high;
        logic protect_trip;
    } sfds_sense_type;

    // per-channel latched record
    typedef struct packed {
        sfds_fault_type turn_on;
        sfds_fault_type permanent;
        logic offset;
    } sfds_record_type;

    typedef enum logic [1:0] {
        SFDS_MODE_OFF,
        SFDS_MODE_PULSE,
        SFDS_MODE_BIASED
    } sfds_amp_mode_type;

endpackage

// *** rtl/sfds_top.sv ***
/*
 * sfds_top: four-channel speaker fault diagnostic sequencer.
 * Assumes the serial front end decodes instruction bytes into the control ports
 * and pulses host_read once per completed host read.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: turn-on test starts on standby exit when host requested diagnostics.
// R2: turn-on test classifies ground, supply, across-load or open-load faults.
// R3: turn-on result held until next test; new test only after host read.
// R4: combined write runs pulse first with stage in standby, then biasing.
// R5: after biasing go permanent; keep turn-on result until a short appears.
// R6: latch output status at end of the 100 ms pulse plateau.
// R7: line-driver thresholds only with low gain and line diagnostic option.
// R8: permanent test reports shorts only, never open load.
// R9: diagnostics off: channels independent, only faulted channel shuts down.
// R10: in restart recheck every 1 ms, reactivate when overload clears.
// R11: with diagnostics enabled, protection trip starts permanent diagnostic.
// R12: recheck 1 ms after trip; no overload means skip and reactivate.
// R13: overload still present at recheck runs a 100 ms diagnostic cycle.
// R14: after the cycle channel goes to restart and result is stored.
// R15: no further cycle until host reads; read re-arms diagnostics.
// R16: host polls status at its own rate, over half a second advised.
// R17: permanent test flags output offset beyond 2 V at zero input.
// R18: diag_enable_bit high enables diagnostics, low defeats them.
// R19: front_gain_select_bit low selects high gain, high selects low gain.
// R20: each channel has its own state machine and fault record.
module sfds_top
    import sfds_pkg::*;
#(
    parameter int NUM_CH = SFDS_NUM_CH,
    parameter int RECHECK_CYC = SFDS_RECHECK_CYC,
    parameter int ACQ_CYC = SFDS_ACQ_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // decoded first_instruction_byte controls
    input wire logic standby_exit,
    input wire logic diag_enable_bit,
    input wire logic front_gain_select_bit,
    input wire logic line_diag_option,
    // host read strobe
    input wire logic host_read,
    // comparator sense per channel
    input wire sfds_sense_type [NUM_CH-1:0] sense,
    // power stage and status
    output logic stage_bias,
    output logic [NUM_CH-1:0] ch_enable,
    output sfds_record_type [NUM_CH-1:0] record
);

    sfds_amp_mode_type mode;
    sfds_amp_mode_type next_mode;
    logic prev_standby_exit;
    logic line_mode;
    logic [NUM_CH-1:0] ch_active;
    logic [NUM_CH-1:0] ton_busy;
    sfds_record_type [NUM_CH-1:0] ch_record;

    wire logic exit_edge = standby_exit && !prev_standby_exit;
    // R1: request arrives with standby exit
    wire logic ton_go = exit_edge && diag_enable_bit;
    wire logic pulse_done = (mode == SFDS_MODE_PULSE) && (ton_busy == '0);

    // R4: pulse first, bias afterwards
    always_comb begin
        next_mode = mode;
        case (mode)
            SFDS_MODE_OFF: begin
                if (ton_go) next_mode = SFDS_MODE_PULSE;
                else if (exit_edge) next_mode = SFDS_MODE_BIASED;
            end
            SFDS_MODE_PULSE: begin
                if (!standby_exit) next_mode = SFDS_MODE_OFF;
                else if (pulse_done) next_mode = SFDS_MODE_BIASED;
            end
            SFDS_MODE_BIASED: begin
                if (!standby_exit) next_mode = SFDS_MODE_OFF;
            end
            default: next_mode = SFDS_MODE_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= SFDS_MODE_OFF;
            prev_standby_exit <= 1'b0;
            line_mode <= 1'b0;
        end else begin
            mode <= next_mode;
            prev_standby_exit <= standby_exit;
            // R7: line thresholds need low gain and option
            // R19: gain bit high is low gain
            line_mode <= front_gain_select_bit && line_diag_option;
        end
    end

    wire logic biased = (mode == SFDS_MODE_BIASED);

    // R20: one sequencer per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            sfds_channel #(
                .RECHECK_CYC(RECHECK_CYC),
                .ACQ_CYC(ACQ_CYC)
            ) u_ch (
                .clk(clk),
                .rst_n(rst_n),
                // R18: diagnostics gate
                .diag_en(diag_enable_bit),
                .line_mode(line_mode),
                .biased(biased),
                .turn_on_go(ton_go),
                .rearm(host_read),
                .sense(sense[g]),
                .ch_active(ch_active[g]),
                .turn_on_busy(ton_busy[g]),
                .record(ch_record[g])
            );
        end
    endgenerate

    // R5: results are each channel record, registered one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_bias <= 1'b0;
            ch_enable <= '0;
            record <= '0;
        end else begin
            stage_bias <= biased;
            // R9: per-channel shutdown
            ch_enable <= biased ? ch_active : '0;
            record <= ch_record;
        end
    end

    // R4: stage stays unbiased during the pulse
    chk_pulse_standby: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == SFDS_MODE_PULSE) |=> (!stage_bias && ch_enable == '0))
        else $error("stage biased during test pulse");
    // R4: biasing follows the finished pulse
    chk_bias_after: assert property (@(posedge clk) disable iff (!rst_n)
        (pulse_done && standby_exit) |=> mode == SFDS_MODE_BIASED)
        else $error("stage not biased after test pulse");
    // R1: pulse launch follows request
    chk_ton_launch: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == SFDS_MODE_OFF && ton_go) |=> mode == SFDS_MODE_PULSE)
        else $error("turn-on test not launched");
    // R9: outputs off when unbiased
    chk_unbiased_off: assert property (@(posedge clk) disable iff (!rst_n)
        !biased |=> ch_enable == '0)
        else $error("channel enabled while unbiased");
    // R7: high gain keeps line mode off
    chk_line_sel: assert property (@(posedge clk) disable iff (!rst_n)
        !front_gain_select_bit |=> !line_mode)
        else $error("line thresholds with high gain");

endmodule

`default_nettype wire

// *** testbench/sfds_load_model.sv ***
/*
 * sfds_load_model: speaker wiring seen by the four outputs, as comparator levels.
 * Assumes load conditions set by the bench and the channel enables of the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none

module sfds_load_model
    import sfds_pkg::*;
(
    // playing state
    input wire logic [SFDS_NUM_CH-1:0] ch_enable,
    // load condition per channel
    input wire logic [SFDS_NUM_CH-1:0][2:0] fault,
    input wire logic [SFDS_NUM_CH-1:0] line_load,
    input wire logic [SFDS_NUM_CH-1:0] glitch,
    input wire logic [SFDS_NUM_CH-1:0] offset_dc,
    // comparator levels
    output var sfds_sense_type [SFDS_NUM_CH-1:0] sense
);
    always_comb begin
        for (int i = 0; i < SFDS_NUM_CH; i++) begin
            sense[i] = '0;
            sense[i].short_gnd = (fault[i] == SFDS_FLT_GND);
            sense[i].short_vs = (fault[i] == SFDS_FLT_VS);
            sense[i].load_short_spk = (fault[i] == SFDS_FLT_ACROSS);
            sense[i].load_open_spk = (fault[i] == SFDS_FLT_OPEN);
            // a load between the two across-load limits only trips line thresholds
            sense[i].load_short_line = (fault[i] == SFDS_FLT_ACROSS) | line_load[i];
            sense[i].load_open_line = (fault[i] == SFDS_FLT_OPEN);
            sense[i].offset_high = offset_dc[i];
            // protection trips on a short while the channel drives current, or whenever glitch is set
            sense[i].protect_trip = glitch[i] | (ch_enable[i] & (fault[i] inside {3'h1, 3'h2, 3'h3}));
        end
    end
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
/*
 * tb_top: self-checking bench for the four-channel fault diagnostic sequencer.
 * Assumes shortened counts RECHECK_CYC=20 and ACQ_CYC=50 and the load model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sfds_pkg::*;
    localparam int RCK = 20;
    localparam int ACQ = 50;
    logic clk = 0, rst_n = 0, standby_exit = 0, diag_enable_bit = 0, host_read = 0;
    logic front_gain_select_bit = 0, line_diag_option = 0, stage_bias;
    logic [3:0][2:0] fault = '0;
    logic [3:0] line_load = '0, glitch = '0, offset_dc = '0, ch_enable;
    sfds_sense_type [3:0] sense;
    sfds_record_type [3:0] record;
    int num_errors = 0, compares = 0, cycles = 0;

    always #5 clk = ~clk;

    sfds_top #(.NUM_CH(4), .RECHECK_CYC(RCK), .ACQ_CYC(ACQ)) i_dut (.clk(clk), .rst_n(rst_n),
        .standby_exit(standby_exit), .diag_enable_bit(diag_enable_bit),
        .front_gain_select_bit(front_gain_select_bit), .line_diag_option(line_diag_option),
        .host_read(host_read), .sense(sense), .stage_bias(stage_bias),
        .ch_enable(ch_enable), .record(record));

    sfds_load_model i_load (.ch_enable(ch_enable), .fault(fault), .line_load(line_load),
        .glitch(glitch), .offset_dc(offset_dc), .sense(sense));

    task automatic test_done;
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic read_pulse;
        host_read = 1;
        tick(1);
        host_read = 0;
        tick(3);
    endtask

    task automatic wait_en(input int ch, input logic val, input int maxc);
        for (int k = 0; k < maxc && ch_enable[ch] !== val; k++) tick(1);
        check("ch_enable", {2'h0, ch_enable[ch]}, {2'h0, val});
    endtask

    task automatic turn_on(input logic gain, input logic line);
        standby_exit = 0;
        diag_enable_bit = 0;
        tick(5);
        read_pulse();
        front_gain_select_bit = gain;
        line_diag_option = line;
        diag_enable_bit = 1;
        standby_exit = 1;
        tick(ACQ - 5);
        check("bias_in_pulse", {2'h0, stage_bias}, 3'h0);
        check("enable_in_pulse", {2'h0, |ch_enable}, 3'h0);
        for (int k = 0; k < 30 && stage_bias !== 1'b1; k++) tick(1);
        check("bias_after", {2'h0, stage_bias}, 3'h1);
        tick(3);
    endtask

    initial begin
        tick(5);
        rst_n = 1;
        tick(2);
        fault = {SFDS_FLT_OPEN, SFDS_FLT_ACROSS, SFDS_FLT_VS, SFDS_FLT_GND};
        turn_on(0, 0);
        for (int i = 0; i < 4; i++) check("turn_on", record[i].turn_on, fault[i]);
        fault = '0;
        for (int i = 0; i < 4; i++) wait_en(i, 1, 2 * RCK + 10);
        check("turn_on kept", record[0].turn_on, SFDS_FLT_GND);
        $display("test turn_on done");

        line_load[2] = 1;
        turn_on(1, 1);
        check("line across", record[2].turn_on, SFDS_FLT_ACROSS);
        turn_on(0, 1);
        check("high gain", record[2].turn_on, SFDS_FLT_NONE);
        turn_on(1, 0);
        check("no line opt", record[2].turn_on, SFDS_FLT_NONE);
        line_load = '0;
        for (int i = 0; i < 4; i++) wait_en(i, 1, 2 * RCK + 10);
        $display("test line_mode done");

        read_pulse();
        glitch[0] = 1;
        tick(2);
        glitch[0] = 0;
        wait_en(0, 0, 5);
        tick(RCK - 8);
        check("early restart", {2'h0, ch_enable[0]}, 3'h0);
        wait_en(0, 1, 15);
        check("glitch perm", record[0].permanent, SFDS_FLT_NONE);
        fault[1] = SFDS_FLT_GND;
        tick(RCK + ACQ - 10);
        check("cycle length", record[1].permanent, SFDS_FLT_NONE);
        tick(25);
        check("perm gnd", record[1].permanent, SFDS_FLT_GND);
        check("ch off", {2'h0, ch_enable[1]}, 3'h0);
        check("others on", {2'h0, ch_enable[0] & ch_enable[2] & ch_enable[3]}, 3'h1);
        fault[1] = SFDS_FLT_NONE;
        wait_en(1, 1, 2 * RCK + 10);
        // a fresh trip without a read must not start a second cycle
        fault[1] = SFDS_FLT_VS;
        tick(RCK + ACQ + 20);
        check("no rearm", record[1].permanent, SFDS_FLT_GND);
        check("restart held", {2'h0, ch_enable[1]}, 3'h0);
        fault[1] = SFDS_FLT_NONE;
        wait_en(1, 1, 2 * RCK + 10);
        read_pulse();
        fault[3] = SFDS_FLT_OPEN;
        glitch[3] = 1;
        tick(RCK + ACQ + 15);
        check("no open perm", record[3].permanent, SFDS_FLT_NONE);
        glitch[3] = 0;
        fault[3] = SFDS_FLT_NONE;
        wait_en(3, 1, 2 * RCK + 10);
        $display("test permanent done");

        offset_dc[2] = 1;
        read_pulse();
        tick(30);
        read_pulse();
        check("offset set", {2'h0, record[2].offset}, 3'h1);
        offset_dc[2] = 0;
        read_pulse();
        tick(30);
        read_pulse();
        check("offset clear", {2'h0, record[2].offset}, 3'h0);
        $display("test offset done");

        diag_enable_bit = 0;
        fault[2] = SFDS_FLT_GND;
        wait_en(2, 0, 10);
        check("others play", {2'h0, ch_enable[0] & ch_enable[1] & ch_enable[3]}, 3'h1);
        tick(RCK + ACQ + 10);
        check("no diag off", record[2].permanent, SFDS_FLT_NONE);
        fault[2] = SFDS_FLT_NONE;
        wait_en(2, 1, RCK + 10);
        $display("test diag_off done");
        test_done();
    end
endmodule

`default_nettype wire
